// [spick_map.svh]
// Notes on behaviour
// - Generator input is mclk/4 when source select is 1, else external source clock.
// - High phase lasts divider/2+1 inputs if even, (divider+1)/2 if odd, one input if zero.
// - Low phase lasts divider/2 inputs if even, (divider+1)/2 if odd, one input if zero.
// - In master mode, output delay enable holds only the first data bit 4 to 8 mclk periods longer.
// - Master with both sync polarities set drives an inverted, active-low select.
// - Slave inverts the active-low select seen on both frame-sync pins.
// - Master asserts select before the clock rises and starts on a rising edge.
// - Mode 10b, polarity 0: sample on falling edge, change data on rising edge.
// - Mode 11b, polarity 0: sample on rising edge, change data on falling edge.
// - Master releases data output after the last bit, timed from a clock edge.
// - Slave releases data output once select returns high after the last bit.
// - Slave drives its first bit after select falls, without a clock edge.
// - With generator resync, rx frame sync is sampled on the source clock rising edge.
// - Serial clock period is 1 + divider generator input periods, or 2 when divider is zero.
`ifndef SPICK_MAP_SVH
`define SPICK_MAP_SVH
`define SPICK_WORD_BITS 8
`define SPICK_CNT_W 8
`define SPICK_QUARTER_DIV 2'h3
`define SPICK_MODE_SAMPLE_FALL 2'h2
`define SPICK_MODE_SAMPLE_RISE 2'h3
`define SPICK_MCLK_NS 20
`define SPICK_DLY_MIN_P 4
`define SPICK_DLY_CYC ((`SPICK_DLY_MIN_P * `SPICK_MCLK_NS + `SPICK_MCLK_NS - 1) / `SPICK_MCLK_NS)
`endif

// [spick_pkg.sv]
package spick_pkg;
  typedef enum logic [1:0] {
    SPICK_IDLE = 2'b00,
    SPICK_LEAD = 2'b01,
    SPICK_SHIFT = 2'b11,
    SPICK_DONE = 2'b10
  } spick_state_t;
endpackage : spick_pkg

// [spick_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer between the user and the shifter.
module spick_buf2 (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] mem_q [0:1];
  logic [7:0] mem_d [0:1];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d, wr_q, wr_d;
  logic push, pop;

  // Pointers and storage update.
  always_comb begin
    push = in_valid && (cnt_q != 2'h2);
    pop = out_ready && (cnt_q != 2'h0);
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    in_ready = (cnt_q != 2'h2);
    out_valid = (cnt_q != 2'h0);
    out_data = mem_q[rd_q];
  end

  // Registers only.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end
endmodule : spick_buf2
`default_nettype wire

// [spick_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spick_map.svh"
// Clock generator and clock-stop serial port core, master or slave.
module spick_core (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic master_mode,
  input wire logic gen_source_select,
  input wire logic [7:0] clock_divider_value,
  input wire logic [1:0] clock_stop_mode,
  input wire logic tx_clock_polarity,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic tx_out_delay_enable,
  input wire logic gen_frame_resync,
  input wire logic ext_source_clock,
  input wire logic tx_clock_in,
  input wire logic tx_frame_sync_in,
  input wire logic rx_frame_sync_in,
  input wire logic serial_data_in,
  output logic tx_serial_clock,
  output logic tx_clock_oe,
  output logic tx_frame_sync,
  output logic tx_sync_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_resync
);
  import spick_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] s1_q, s2_q, s3_q;
  // Pins pass two flops; s3 is a third stage used only for edges.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 5'h1f;
      s2_q <= 5'h1f;
      s3_q <= 5'h1f;
    end else begin
      s1_q <= {ext_source_clock, tx_clock_in, tx_frame_sync_in, rx_frame_sync_in,
               serial_data_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic src_rise, sclk_rise, sclk_fall, sel_in, rsel_in, din;
  always_comb begin
    src_rise = s2_q[4] && !s3_q[4];
    sclk_rise = s2_q[3] && !s3_q[3];
    sclk_fall = !s2_q[3] && s3_q[3];
    sel_in = !s2_q[2];
    rsel_in = !s2_q[1];
    din = s2_q[0];
  end

  // ----------------------------------------------------------------
  // Sample-rate generator
  // ----------------------------------------------------------------
  logic [1:0] pre_q, pre_d;
  logic [7:0] ph_q, ph_d;
  logic gen_tick, ck_q, ck_d, run;
  // High and low phase lengths for the current divider value.
  function automatic logic [7:0] phase_len(input logic [7:0] div, input logic high);
    if (div == 8'h00 || div[0]) begin
      phase_len = 8'((9'(div) + 9'h001) >> 1);
    end else begin
      phase_len = high ? (div >> 1) + 8'h01 : div >> 1;
    end
  endfunction : phase_len

  // Generator input is mclk/4 or the synchronised source clock edge.
  always_comb begin
    // The prescaler restarts with every word so the first tick has a fixed lead.
    pre_d = run ? pre_q + 2'h1 : 2'h0;
    gen_tick = gen_source_select ? (pre_q == `SPICK_QUARTER_DIV) : src_rise;
    ph_d = ph_q;
    ck_d = ck_q;
    if (!run) begin
      ph_d = 8'h00;
      ck_d = 1'b0;
    end else if (gen_tick) begin
      if (ph_q + 8'h01 >= phase_len(clock_divider_value, ck_q)) begin
        ph_d = 8'h00;
        ck_d = !ck_q;
      end else begin
        ph_d = ph_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  spick_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, rx_q, rx_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] dly_q, dly_d;
  logic oe_q, oe_d, sel_q, sel_d, rv_q, rv_d, rs_q, rs_d, so_q, so_d;
  logic [7:0] bdata;
  logic bvalid, take, ck_rise, ck_fall, smp_edge, chg_edge, sel_act;

  spick_buf2 u_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(bdata),
    .out_valid(bvalid),
    .out_ready(take)
  );

  // Edge selection by mode and role, then the word state machine.
  always_comb begin
    run = master_mode && (st_q == SPICK_SHIFT) && (dly_q == 4'h0);
    ck_rise = master_mode ? (ck_d && !ck_q) : sclk_rise;
    ck_fall = master_mode ? (!ck_d && ck_q) : sclk_fall;
    if (clock_stop_mode == `SPICK_MODE_SAMPLE_RISE) begin
      smp_edge = ck_rise;
      chg_edge = ck_fall;
    end else begin
      smp_edge = ck_fall;
      chg_edge = ck_rise;
    end
    sel_act = master_mode ? sel_q : (sel_in || rsel_in);
    take = 1'b0;
    st_d = st_q;
    sh_d = sh_q;
    rx_d = rx_q;
    bit_d = bit_q;
    dly_d = (dly_q != 4'h0 && st_q == SPICK_SHIFT) ? dly_q - 4'h1 : dly_q;
    oe_d = oe_q;
    sel_d = sel_q;
    rv_d = 1'b0;
    rs_d = gen_frame_resync && src_rise && s2_q[1];
    so_d = so_q;
    case (st_q)
      SPICK_IDLE: begin
        if (bvalid && (master_mode || sel_act)) begin
          take = 1'b1;
          sh_d = bdata;
          so_d = bdata[7];
          bit_d = 4'h0;
          oe_d = 1'b1;
          sel_d = master_mode;
          dly_d = tx_out_delay_enable ? 4'(`SPICK_DLY_CYC) : 4'h0;
          st_d = master_mode ? SPICK_LEAD : SPICK_SHIFT;
        end
      end
      SPICK_LEAD: begin
        st_d = SPICK_SHIFT;
      end
      SPICK_SHIFT: begin
        if (smp_edge) begin
          rx_d = {rx_q[6:0], din};
          bit_d = bit_q + 4'h1;
        end
        if (chg_edge && bit_q != 4'h0 && bit_q < 4'(`SPICK_WORD_BITS)) begin
          sh_d = {sh_q[6:0], 1'b0};
          so_d = sh_q[6];
        end
        // A master lets the last high phase run out before the clock rests.
        if (bit_q == 4'(`SPICK_WORD_BITS) && (!master_mode || !ck_q)) begin
          rv_d = 1'b1;
          st_d = SPICK_DONE;
          if (master_mode) begin
            oe_d = 1'b0;
          end
        end
        if (!master_mode && !sel_act) begin
          oe_d = 1'b0;
          st_d = SPICK_IDLE;
        end
      end
      SPICK_DONE: begin
        sel_d = 1'b0;
        if (master_mode || !sel_act) begin
          oe_d = 1'b0;
          st_d = SPICK_IDLE;
        end
      end
      default: begin
        st_d = SPICK_IDLE;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 2'h0;
      ph_q <= 8'h00;
      ck_q <= 1'b0;
      st_q <= SPICK_IDLE;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 4'h0;
      dly_q <= 4'h0;
      oe_q <= 1'b0;
      sel_q <= 1'b0;
      rv_q <= 1'b0;
      rs_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ph_q <= ph_d;
      ck_q <= ck_d;
      st_q <= st_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      bit_q <= bit_d;
      dly_q <= dly_d;
      oe_q <= oe_d;
      sel_q <= sel_d;
      rv_q <= rv_d;
      rs_q <= rs_d;
      so_q <= so_d;
    end
  end

  // Output flops for pins; polarity applied inside the register.
  logic tck_q, tfs_q, tfo_q, tco_q, dx_q, dxo_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tck_q <= 1'b0;
      tfs_q <= 1'b1;
      tfo_q <= 1'b0;
      tco_q <= 1'b0;
      dx_q <= 1'b0;
      dxo_q <= 1'b0;
    end else begin
      tck_q <= ck_d ^ tx_clock_polarity;
      tfs_q <= (tx_sync_polarity && rx_sync_polarity) ? !sel_d : sel_d;
      tfo_q <= master_mode;
      tco_q <= master_mode;
      dx_q <= so_d;
      dxo_q <= oe_d;
    end
  end
  assign tx_serial_clock = tck_q;
  assign tx_clock_oe = tco_q;
  assign tx_frame_sync = tfs_q;
  assign tx_sync_oe = tfo_q;
  assign serial_data_out = dx_q;
  assign serial_data_oe = dxo_q;
  assign rx_data = rx_q;
  assign rx_valid = rv_q;
  assign rx_resync = rs_q;
endmodule : spick_core
`default_nettype wire

// [spick_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin checks of clock shape, select framing and data release.
module spick_core_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic master_mode,
  input wire logic gen_source_select,
  input wire logic [7:0] clock_divider_value,
  input wire logic tx_clock_polarity,
  input wire logic tx_sync_polarity,
  input wire logic gen_frame_resync,
  input wire logic tx_frame_sync_in,
  input wire logic tx_serial_clock,
  input wire logic tx_clock_oe,
  input wire logic tx_frame_sync,
  input wire logic serial_data_oe,
  input wire logic rx_valid,
  input wire logic rx_resync
);
  logic [9:0] hi_q;
  logic [9:0] hi_d;
  logic [9:0] hi_x;
  // High time so far, and the high time a quarter-rate generator gives.
  always_comb begin
    hi_d = tx_serial_clock ? hi_q + 10'h001 : 10'h000;
    hi_x = {1'b0, clock_divider_value, 1'b0} + (clock_divider_value[0] ? 10'h002 : 10'h004);
  end
  // Registers the high-time count.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) hi_q <= 10'h000;
    else hi_q <= hi_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Clock shape and rest, select level, pin release and resync gating.
  clk_high_a: assert property (
    master_mode && gen_source_select && !tx_clock_polarity && $fell(tx_serial_clock)
    |-> hi_q == hi_x) else $error("high phase wrong");
  sel_lead_a: assert property (
    master_mode && $fell(tx_frame_sync) |-> tx_serial_clock == tx_clock_polarity)
    else $error("clock moved first");
  clk_rest_a: assert property (
    master_mode && tx_frame_sync && $past(tx_frame_sync) && $past(tx_serial_clock) ==
    tx_clock_polarity |-> tx_serial_clock == tx_clock_polarity) else $error("idle clock ran");
  sel_low_a: assert property (
    master_mode && tx_sync_polarity && serial_data_oe |-> !tx_frame_sync)
    else $error("select high in word");
  clk_oe_a: assert property (
    $stable(master_mode) |=> tx_clock_oe == $past(master_mode)) else $error("clock enable wrong");
  m_rel_a: assert property (
    master_mode && $fell(serial_data_oe) |-> ##[0:1] tx_frame_sync) else $error("late release");
  s_rel_a: assert property (
    !master_mode && tx_frame_sync_in [*6] |-> !serial_data_oe) else $error("slave drives");
  resync_a: assert property (
    !gen_frame_resync && !$past(gen_frame_resync) |-> !rx_resync) else $error("stray resync");
  cover property (master_mode && rx_valid);
  cover property (!master_mode && rx_valid);
  cover property (rx_resync);
endmodule : spick_core_checker

bind spick_core spick_core_checker i_spick_core_checker (
  .mclk, .reset_n, .master_mode, .gen_source_select, .clock_divider_value,
  .tx_clock_polarity, .tx_sync_polarity, .gen_frame_resync, .tx_frame_sync_in,
  .tx_serial_clock, .tx_clock_oe, .tx_frame_sync, .serial_data_oe, .rx_valid, .rx_resync
);
`default_nettype wire

// [spick_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side: a slave when the port is master, a master when it is slave.
module spick_peer (
  input wire logic role_master,
  input wire logic [1:0] mode,
  input wire logic [7:0] word,
  input wire logic dut_clk,
  input wire logic dut_sel,
  input wire logic dut_do,
  output logic pclk,
  output logic psel,
  output logic pdo,
  output logic [7:0] got
);
  wire logic sck;
  wire logic sel;
  logic [7:0] sh;
  logic pend;
  assign sck = role_master ? pclk : dut_clk;
  assign sel = role_master ? psel : dut_sel;
  initial begin
    pclk = 1'b0;
    psel = 1'b1;
    pdo = 1'b0;
    pend = 1'b0;
  end
  // Select low shows the first bit; select high turns the line to its inverse.
  always @(sel) begin
    if (!sel) begin
      sh = word;
      pdo = word[7];
      pend = 1'b0;
    end else begin
      pdo = ~pdo;
    end
  end
  // Sample on rising edges in mode 11b, falling in 10b; shift on the next edge.
  always @(sck) begin
    if (!sel && sck == mode[0]) begin
      got = {got[6:0], dut_do};
      pend = 1'b1;
    end else if (!sel && pend) begin
      sh = {sh[6:0], 1'b0};
      pdo = sh[7];
      pend = 1'b0;
    end
  end
  // One word as master; the clock rests low outside the frame.
  task automatic frame(input int half);
    psel = 1'b0;
    repeat (8) begin
      #(half);
      pclk = 1'b1;
      #(half);
      pclk = 1'b0;
    end
    #(half);
    psel = 1'b1;
  endtask : frame
endmodule : spick_peer
`default_nettype wire

// [spick_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module spick_core_tb;
  logic mclk = 1'b0, ext_source_clock = 1'b0, reset_n = 1'b0, master_mode = 1'b1;
  logic gen_source_select = 1'b1, tx_clock_polarity = 1'b0, tx_sync_polarity = 1'b1;
  logic rx_sync_polarity = 1'b1, tx_out_delay_enable = 1'b0, gen_frame_resync = 1'b0;
  logic tx_valid = 1'b0, tx_ready, rx_valid, rx_resync, pclk, psel, pdo;
  logic [7:0] clock_divider_value = 8'h01, tx_data = 8'h00, rx_data, got;
  logic [1:0] clock_stop_mode = 2'h2;
  logic tx_serial_clock, tx_clock_oe, tx_frame_sync, tx_sync_oe, serial_data_out, serial_data_oe;
  wire logic clk_w;
  wire logic sel_w;
  int mismatches = 0, checked = 0;
  // Pin levels come from whichever side enables its driver.
  assign clk_w = tx_clock_oe ? tx_serial_clock : pclk;
  assign sel_w = tx_sync_oe ? tx_frame_sync : psel;
  always #10 mclk = ~mclk;
  always #70 ext_source_clock = ~ext_source_clock;
  spick_core i_spick_core (
    .mclk, .reset_n, .master_mode, .gen_source_select, .clock_divider_value, .clock_stop_mode,
    .tx_clock_polarity, .tx_sync_polarity, .rx_sync_polarity, .tx_out_delay_enable,
    .gen_frame_resync, .ext_source_clock, .tx_clock_in(clk_w), .tx_frame_sync_in(sel_w),
    .rx_frame_sync_in(sel_w), .serial_data_in(pdo), .tx_serial_clock, .tx_clock_oe,
    .tx_frame_sync, .tx_sync_oe, .serial_data_out, .serial_data_oe, .tx_data, .tx_valid,
    .tx_ready, .rx_data, .rx_valid, .rx_resync
  );
  spick_peer i_spick_peer (
    .role_master(!master_mode), .mode(clock_stop_mode), .word(8'h5a), .dut_clk(clk_w),
    .dut_sel(sel_w), .dut_do(serial_data_out), .pclk, .psel, .pdo, .got
  );
  task automatic end_sim;
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic guard(input int i);
    if (i >= 3000) begin
      mismatches++;
      end_sim;
    end
  endtask : guard
  task automatic wait_rx;
    int i;
    step(1);
    for (i = 0; i < 3000 && rx_valid !== 1'b1; i++) step(1);
    guard(i);
  endtask : wait_rx
  // Offers a word and holds it until the buffer takes it.
  task automatic push(input logic [7:0] w);
    int i;
    tx_data = w;
    tx_valid = 1'b1;
    for (i = 0; i < 3000 && tx_ready !== 1'b1; i++) step(1);
    guard(i);
    step(1);
  endtask : push
  task automatic t_master(input logic [1:0] md, input logic [7:0] dv, input logic src,
                          input logic dly, output int lead);
    int i;
    master_mode = 1'b1;
    clock_stop_mode = md;
    clock_divider_value = dv;
    gen_source_select = src;
    tx_out_delay_enable = dly;
    step(2);
    push(8'hc3);
    tx_valid = 1'b0;
    for (i = 0; i < 3000 && tx_frame_sync !== 1'b0; i++) step(1);
    guard(i);
    for (lead = 0; lead < 3000 && tx_serial_clock !== 1'b1; lead++) step(1);
    guard(lead);
    wait_rx;
    `CHK("rx_data", 8'h5a, rx_data)
    `CHK("peer_got", 8'hc3, got)
    `CHK("sync_oe", 1'b1, tx_sync_oe)
    step(4);
    `CHK("data_oe", 1'b0, serial_data_oe)
  endtask : t_master
  task automatic t_slave(input logic [1:0] md);
    master_mode = 1'b0;
    clock_stop_mode = md;
    clock_divider_value = 8'h01;
    gen_source_select = 1'b1;
    step(2);
    push(8'ha6);
    tx_valid = 1'b0;
    fork
      i_spick_peer.frame(400);
      wait_rx;
    join
    step(6);
    `CHK("rx_data", 8'h5a, rx_data)
    `CHK("peer_got", 8'ha6, got)
    `CHK("data_oe", 1'b0, serial_data_oe)
    `CHK("sync_oe", 1'b0, tx_sync_oe)
  endtask : t_slave
  // Fills the two-entry buffer until it refuses, then drains it in order.
  task automatic t_fill;
    int n;
    int k;
    for (n = 0; n < 6 && tx_ready === 1'b1; n++) push(8'h10 + n[7:0]);
    tx_valid = 1'b0;
    `CHK("refused", 1'b0, tx_ready)
    for (k = 0; k < n; k++) begin
      wait_rx;
      `CHK("peer_got", 8'h10 + k[7:0], got)
    end
  endtask : t_fill
  task automatic t_resync;
    int i;
    gen_frame_resync = 1'b1;
    for (i = 0; i < 3000 && rx_resync !== 1'b1; i++) step(1);
    guard(i);
    `CHK("rx_resync", 1'b1, rx_resync)
    gen_frame_resync = 1'b0;
  endtask : t_resync
  // Reset, then master words in both modes, buffer, resync and slave words.
  initial begin
    int l0;
    int l1;
    repeat (4) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    step(1);
    t_master(2'h2, 8'h01, 1'b1, 1'b0, l0);
    t_master(2'h2, 8'h01, 1'b1, 1'b1, l1);
    `CHK("first_bit_delay", 1'b1, (l1 - l0) inside {[4:8]})
    t_master(2'h3, 8'h02, 1'b1, 1'b0, l0);
    t_master(2'h3, 8'h03, 1'b0, 1'b0, l0);
    t_fill;
    t_resync;
    t_slave(2'h3);
    t_slave(2'h2);
    end_sim;
  end
endmodule : spick_core_tb
`default_nettype wire
